// [include/acp_consts.svh]
`ifndef ACP_CONSTS_SVH
`define ACP_CONSTS_SVH

// Data path shape.
`define ACP_DATA_W            14
`define ACP_LATENCY           10
`define ACP_DIV_MAX           8

// Clock rate and retimer settle time.
`define ACP_CLK_FREQ_KHZ      10000
`define ACP_CLK_PERIOD_PS     (1000000000 / `ACP_CLK_FREQ_KHZ)
`define ACP_DCS_SETTLE_MIN_NS 1500
`define ACP_DCS_SETTLE_MAX_NS 5000
`define ACP_DCS_SETTLE_CYC    ((`ACP_DCS_SETTLE_MIN_NS * 1000 + `ACP_CLK_PERIOD_PS - 1) / `ACP_CLK_PERIOD_PS)

// Register offsets.
`define ACP_REG_PWR           8'h08
`define ACP_REG_DCS           8'h09
`define ACP_REG_DIV           8'h0B
`define ACP_REG_OUT           8'h14

// Field positions.
`define ACP_PWR_MODE_LSB      0
`define ACP_DCS_EN_BIT        0
`define ACP_DCS_LOCK_BIT      7
`define ACP_DIV_LSB           0
`define ACP_OUT_FMT_LSB       0
`define ACP_OUT_TRI_BIT       4
`define ACP_OUT_SWING_BIT     6

// Reset values.
`define ACP_PWR_RESET         8'h00
`define ACP_DCS_RESET         8'h01
`define ACP_DIV_RESET         8'h00
`define ACP_OUT_RESET         8'h01

// Writable bits of each register.
`define ACP_PWR_WMASK         8'h03
`define ACP_DCS_WMASK         8'h01
`define ACP_DIV_WMASK         8'h07
`define ACP_OUT_WMASK         8'h53

`endif

// [include/acp_pkg.sv]
package acp_pkg;

  typedef enum logic [1:0] {
    ACP_PWR_NORMAL  = 2'h0,
    ACP_PWR_DOWN    = 2'h1,
    ACP_PWR_STANDBY = 2'h2,
    ACP_PWR_RSVD    = 2'h3
  } acp_pwr_mode_t;

  typedef enum logic [1:0] {
    ACP_FMT_OFFSET = 2'h0,
    ACP_FMT_TWOS   = 2'h1,
    ACP_FMT_GRAY   = 2'h2,
    ACP_FMT_RSVD   = 2'h3
  } acp_fmt_t;

  typedef enum logic [1:0] {
    ACP_DCS_OFF    = 2'h0,
    ACP_DCS_SETTLE = 2'h1,
    ACP_DCS_LOCKED = 2'h3
  } acp_dcs_state_t;

endpackage

// [include/acp_pipe_if.sv]
`timescale 1ns/1ps
interface acp_pipe_if #(
  parameter int W = 14
);
  logic         adv;
  logic         flush;
  logic [W-1:0] wdata;
  logic [W-1:0] rdata;
  logic         rvalid;

  modport ctl   (output adv, output flush, output wdata, input rdata, input rvalid);
  modport store (input adv, input flush, input wdata, output rdata, output rvalid);
endinterface

// [rtl/acp_delay_line.sv]
`timescale 1ns/1ps
module acp_delay_line #(
  parameter int W     = 14,
  parameter int DEPTH = 10
) (
  input wire logic  clock_in,
  input wire logic  resetn_in,
  acp_pipe_if.store pipe
);
  import acp_pkg::*;

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [W-1:0]            rdata;
    logic                    rvalid;
  } acp_dl_state_t;

  acp_dl_state_t st_r;
  acp_dl_state_t st_nxt;

  // Each advance reads the oldest word and overwrites it with the newest one.
  always_comb begin
    st_nxt        = st_r;
    st_nxt.rvalid = 1'b0;
    if (pipe.flush) begin
      st_nxt.wp = '0;
    end else if (pipe.adv) begin
      st_nxt.rdata        = st_r.mem[st_r.wp];
      st_nxt.mem[st_r.wp] = pipe.wdata;
      st_nxt.rvalid       = 1'b1;
      if (st_r.wp == AW'(DEPTH - 1)) begin
        st_nxt.wp = '0;
      end else begin
        st_nxt.wp = st_r.wp + AW'(1);
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pipe.rdata  = st_r.rdata;
  assign pipe.rvalid = st_r.rvalid;
endmodule

// [rtl/acp_top.sv]
// What this block does
// - Divide the sample clock by an integer ratio from 1 to 8.
// - Duty cycle retimer is enabled after reset without any write.
// - Locked retimer regenerates the falling edge: 50% duty at even ratios, high one cycle longer than low at odd ratios.
// - Retimer stays unlocked while the clock rate is below about 40 MHz.
// - After a clock frequency change the retimer relocks only after settling.
// - While unlocked the retimer is bypassed and timing follows the input.
// - Power mode field value 01 at 0x08 selects full power-down.
// - Full power-down turns off reference, buffer, bias and internal clock.
// - Full power-down puts all data output drivers in high impedance.
// - Power mode value 10 selects standby, keeping the reference powered.
// - Output drivers select standard or reduced swing signalling.
// - Output coding selects offset binary, twos complement or gray code.
// - Twos complement is the default coding with the documented end codes.
// - Offset binary maps negative full scale to zero, midscale to 10 0000 0000 0000.
// - Bit 4 of output_configuration three-states the data outputs.
// - Each output word appears 10 conversion clock cycles plus one input clock cycle after its sample.
// - New output data is valid one delay after the sampling edge.
// - A data clock output accompanies the data for the capture register.
// - Each control register is eight bits wide.
`timescale 1ns/1ps
`include "acp_consts.svh"
module acp_top #(
  parameter int W          = `ACP_DATA_W,
  parameter int LATENCY    = `ACP_LATENCY,
  parameter int DIV_MAX    = `ACP_DIV_MAX,
  parameter int SETTLE_CYC = `ACP_DCS_SETTLE_CYC
) (
  input  wire logic                    CLOCK_IN,
  input  wire logic                    RESETN_IN,
  input  wire logic [7:0]              REG_ADDR_IN,
  input  wire logic [7:0]              REG_WDATA_IN,
  input  wire logic                    REG_WRITE_IN,
  input  wire logic                    REG_READ_IN,
  output logic      [7:0]              REG_RDATA_OUT,
  input  wire logic [W-1:0]            SAMPLE_DATA_IN,
  input  wire logic                    CLOCK_FREQ_CHANGE_IN,
  input  wire logic                    CLOCK_RATE_LOW_IN,
  output logic                         CONV_CLOCK_OUT,
  output logic                         SAMPLE_STROBE_OUT,
  output logic                         DUTY_CYCLE_RETIMER_ACTIVE_OUT,
  output logic                         DUTY_CYCLE_RETIMER_BYPASS_OUT,
  output acp_pkg::acp_pwr_mode_t       POWER_MODE_OUT,
  output logic                         REF_ENABLE_OUT,
  output logic                         BIAS_ENABLE_OUT,
  output logic                         CORE_CLOCK_ENABLE_OUT,
  output logic      [W-1:0]            DATA_OUT,
  output logic                         DATA_OE_OUT,
  output logic                         OUTPUT_SAMPLE_CLOCK_OUT,
  output logic                         OUTPUT_SAMPLE_CLOCK_OE_OUT,
  output logic                         REDUCED_SWING_OUT
);
  import acp_pkg::*;

  localparam int DW = $clog2(DIV_MAX);
  localparam int CW = $clog2(SETTLE_CYC + 1);
  localparam int FW = $clog2(LATENCY + 1);

  typedef struct packed {
    logic [7:0]     pwr_reg;
    logic [7:0]     dcs_reg;
    logic [7:0]     div_reg;
    logic [7:0]     out_reg;
    logic [7:0]     rdata;
    logic [1:0][2:0] sync;
    logic [1:0]     filt;
    logic           chg_prev;
    logic [DW-1:0]  div_cnt;
    logic           tick;
    logic           conv_clk;
    acp_dcs_state_t duty_cycle_retimer;
    logic [CW-1:0]  settle_cnt;
    logic [FW-1:0]  fill;
    logic           word_ok;
    logic [W-1:0]   data;
    logic           output_sample_clock;
    logic           oe;
    logic           ref_en;
    logic           bias_en;
    logic           clk_en;
  } acp_top_state_t;

  acp_top_state_t st_r;
  acp_top_state_t st_nxt;

  acp_pipe_if #(.W(W)) pipe ();

  logic          run;
  logic          adv;
  logic          chg_evt;
  logic [DW:0]   ratio;
  logic [DW:0]   half;
  acp_pwr_mode_t mode;
  acp_fmt_t      fmt;
  logic [1:0]    async_in;

  // Writable bits per offset; zero marks an unmapped address.
  function automatic logic [7:0] wmask(input logic [7:0] addr);
    case (addr)
      `ACP_REG_PWR: wmask = `ACP_PWR_WMASK;
      `ACP_REG_DCS: wmask = `ACP_DCS_WMASK;
      `ACP_REG_DIV: wmask = `ACP_DIV_WMASK;
      `ACP_REG_OUT: wmask = `ACP_OUT_WMASK;
      default:      wmask = 8'h00;
    endcase
  endfunction

  // Core result arrives in offset binary and is recoded here.
  function automatic logic [W-1:0] encode(input logic [W-1:0] raw, input acp_fmt_t f);
    case (f)
      ACP_FMT_TWOS: encode = {~raw[W-1], raw[W-2:0]};
      ACP_FMT_GRAY: encode = raw ^ (raw >> 1);
      default:      encode = raw;
    endcase
  endfunction

  assign async_in = {CLOCK_RATE_LOW_IN, CLOCK_FREQ_CHANGE_IN};
  assign mode     = acp_pwr_mode_t'(st_r.pwr_reg[`ACP_PWR_MODE_LSB +: 2]);
  assign fmt      = acp_fmt_t'(st_r.out_reg[`ACP_OUT_FMT_LSB +: 2]);
  assign run      = (mode == ACP_PWR_NORMAL) || (mode == ACP_PWR_RSVD);
  assign ratio    = {1'b0, st_r.div_reg[`ACP_DIV_LSB +: DW]} + (DW+1)'(1);
  assign half     = (ratio + (DW+1)'(1)) >> 1;
  assign adv      = run && (st_r.div_cnt == '0);
  assign chg_evt  = st_r.filt[0] && !st_r.chg_prev;

  assign pipe.adv   = adv;
  assign pipe.flush = !run;
  assign pipe.wdata = SAMPLE_DATA_IN;

  always_comb begin
    st_nxt = st_r;

    // Three-stage synchronisers; a change counts once stages two and three agree.
    for (int i = 0; i < 2; i++) begin
      st_nxt.sync[i] = {st_r.sync[i][1:0], async_in[i]};
      if (st_r.sync[i][1] == st_r.sync[i][2]) begin
        st_nxt.filt[i] = st_r.sync[i][2];
      end
    end
    st_nxt.chg_prev = st_r.filt[0];

    // Register writes keep only the implemented bits of each eight-bit register.
    if (REG_WRITE_IN) begin
      case (REG_ADDR_IN)
        `ACP_REG_PWR: st_nxt.pwr_reg = REG_WDATA_IN & `ACP_PWR_WMASK;
        `ACP_REG_DCS: st_nxt.dcs_reg = REG_WDATA_IN & `ACP_DCS_WMASK;
        `ACP_REG_DIV: st_nxt.div_reg = REG_WDATA_IN & `ACP_DIV_WMASK;
        `ACP_REG_OUT: st_nxt.out_reg = REG_WDATA_IN & `ACP_OUT_WMASK;
        default: begin
        end
      endcase
    end

    // Register reads; unmapped addresses and unused bits read as zero.
    if (REG_READ_IN) begin
      case (REG_ADDR_IN)
        `ACP_REG_PWR: st_nxt.rdata = st_r.pwr_reg;
        `ACP_REG_DCS: begin
          st_nxt.rdata = st_r.dcs_reg;
          st_nxt.rdata[`ACP_DCS_LOCK_BIT] = (st_r.duty_cycle_retimer == ACP_DCS_LOCKED);
        end
        `ACP_REG_DIV: st_nxt.rdata = st_r.div_reg;
        `ACP_REG_OUT: st_nxt.rdata = st_r.out_reg;
        default:      st_nxt.rdata = 8'h00 & wmask(REG_ADDR_IN);
      endcase
    end

    // Divider runs only while the internal clock is powered.
    if (!run) begin
      st_nxt.div_cnt = '0;
    end else if ({1'b0, st_r.div_cnt} >= ratio - (DW+1)'(1)) begin
      st_nxt.div_cnt = '0;
    end else begin
      st_nxt.div_cnt = st_r.div_cnt + DW'(1);
    end
    st_nxt.tick = adv;

    // Retimer: off, settling after a disturbance, then locked.
    if (!st_r.dcs_reg[`ACP_DCS_EN_BIT] || st_r.filt[1] || !run) begin
      st_nxt.duty_cycle_retimer        = ACP_DCS_OFF;
      st_nxt.settle_cnt = '0;
    end else begin
      case (st_r.duty_cycle_retimer)
        ACP_DCS_OFF: begin
          st_nxt.duty_cycle_retimer        = ACP_DCS_SETTLE;
          st_nxt.settle_cnt = '0;
        end
        ACP_DCS_SETTLE: begin
          if (chg_evt) begin
            st_nxt.settle_cnt = '0;
          end else if (st_r.settle_cnt >= CW'(SETTLE_CYC - 1)) begin
            st_nxt.duty_cycle_retimer = ACP_DCS_LOCKED;
          end else begin
            st_nxt.settle_cnt = st_r.settle_cnt + CW'(1);
          end
        end
        ACP_DCS_LOCKED: begin
          if (chg_evt) begin
            st_nxt.duty_cycle_retimer        = ACP_DCS_SETTLE;
            st_nxt.settle_cnt = '0;
          end
        end
        default: begin
          st_nxt.duty_cycle_retimer        = ACP_DCS_OFF;
          st_nxt.settle_cnt = '0;
        end
      endcase
    end

    // Internal clock: regenerated half-period when locked, raw pulse otherwise.
    if (!run) begin
      st_nxt.conv_clk = 1'b0;
    end else if (st_r.duty_cycle_retimer == ACP_DCS_LOCKED) begin
      st_nxt.conv_clk = ({1'b0, st_nxt.div_cnt} < half);
    end else begin
      st_nxt.conv_clk = (st_nxt.div_cnt == '0);
    end

    // Pipeline fill: output words start once LATENCY samples are in flight.
    st_nxt.word_ok = 1'b0;
    if (!run) begin
      st_nxt.fill = '0;
    end else if (adv) begin
      st_nxt.word_ok = (st_r.fill == FW'(LATENCY));
      if (st_r.fill != FW'(LATENCY)) begin
        st_nxt.fill = st_r.fill + FW'(1);
      end
    end

    // Output register and data clock update together, once per word.
    if (pipe.rvalid && st_r.word_ok) begin
      st_nxt.data = encode(pipe.rdata, fmt);
      st_nxt.output_sample_clock  = ~st_r.output_sample_clock;
    end

    // Power domains and output drivers.
    st_nxt.ref_en  = (mode != ACP_PWR_DOWN);
    st_nxt.bias_en = run;
    st_nxt.clk_en  = run;
    st_nxt.oe      = run && !st_r.out_reg[`ACP_OUT_TRI_BIT];
  end

  always_ff @(posedge CLOCK_IN) begin
    if (!RESETN_IN) begin
      st_r          <= '0;
      st_r.pwr_reg  <= `ACP_PWR_RESET;
      st_r.dcs_reg  <= `ACP_DCS_RESET;
      st_r.div_reg  <= `ACP_DIV_RESET;
      st_r.out_reg  <= `ACP_OUT_RESET;
      st_r.duty_cycle_retimer      <= ACP_DCS_OFF;
      st_r.ref_en   <= 1'b1;
      st_r.bias_en  <= 1'b1;
      st_r.clk_en   <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  acp_delay_line #(
    .W     (W),
    .DEPTH (LATENCY)
  ) u_delay (
    .clock_in  (CLOCK_IN),
    .resetn_in (RESETN_IN),
    .pipe      (pipe.store)
  );

  assign REG_RDATA_OUT                 = st_r.rdata;
  assign CONV_CLOCK_OUT                = st_r.conv_clk;
  assign SAMPLE_STROBE_OUT             = st_r.tick;
  assign DUTY_CYCLE_RETIMER_ACTIVE_OUT = (st_r.duty_cycle_retimer == ACP_DCS_LOCKED);
  assign DUTY_CYCLE_RETIMER_BYPASS_OUT = (st_r.duty_cycle_retimer != ACP_DCS_LOCKED);
  assign POWER_MODE_OUT                = mode;
  assign REF_ENABLE_OUT                = st_r.ref_en;
  assign BIAS_ENABLE_OUT               = st_r.bias_en;
  assign CORE_CLOCK_ENABLE_OUT         = st_r.clk_en;
  assign DATA_OUT                      = st_r.data;
  assign DATA_OE_OUT                   = st_r.oe;
  assign OUTPUT_SAMPLE_CLOCK_OUT       = st_r.output_sample_clock;
  assign OUTPUT_SAMPLE_CLOCK_OE_OUT    = st_r.oe;
  assign REDUCED_SWING_OUT             = st_r.out_reg[`ACP_OUT_SWING_BIT];
endmodule

// [testbench/acp_checker.sv]
`timescale 1ns/1ps
module acp_checker
  import acp_pkg::*;
#(
  parameter int W          = 14,
  parameter int SETTLE_CYC = 15
) (
  input wire logic          CLOCK_IN,
  input wire logic          RESETN_IN,
  input wire logic [7:0]    REG_ADDR_IN,
  input wire logic [7:0]    REG_WDATA_IN,
  input wire logic          REG_WRITE_IN,
  input wire logic          REG_READ_IN,
  input wire logic [7:0]    REG_RDATA_OUT,
  input wire logic [W-1:0]  SAMPLE_DATA_IN,
  input wire acp_pwr_mode_t POWER_MODE_OUT,
  input wire logic          REF_ENABLE_OUT,
  input wire logic          BIAS_ENABLE_OUT,
  input wire logic          CORE_CLOCK_ENABLE_OUT,
  input wire logic [W-1:0]  DATA_OUT,
  input wire logic          DATA_OE_OUT,
  input wire logic          OUTPUT_SAMPLE_CLOCK_OUT,
  input wire logic          DUTY_CYCLE_RETIMER_ACTIVE_OUT
);
  logic [2:0] div_r;
  logic [1:0] fmt_r;
  logic [3:0] quiet_r;
  logic [4:0] low_r;
  wire        wr_pwr = REG_WRITE_IN && REG_ADDR_IN == 8'h08;
  function automatic logic [W-1:0] coded(input logic [W-1:0] v, input logic [1:0] f);
    case (f)
      2'h1: return {~v[W-1], v[W-2:0]};
      2'h2: return v ^ (v >> 1);
      default: return v;
    endcase
  endfunction
  // Shadow of the divider and coding fields, and cycles since the last write.
  always_ff @(posedge CLOCK_IN) begin
    if (!RESETN_IN) begin
      div_r <= 3'h0;
      fmt_r <= 2'h1;
      quiet_r <= 4'h0;
      low_r <= 5'h00;
    end else begin
      quiet_r <= REG_WRITE_IN ? 4'h0 : (quiet_r == 4'hF ? quiet_r : quiet_r + 4'h1);
      low_r <= DUTY_CYCLE_RETIMER_ACTIVE_OUT ? 5'h00 : (low_r == 5'h1F ? low_r : low_r + 5'h01);
      if (REG_WRITE_IN && REG_ADDR_IN == 8'h0B) div_r <= REG_WDATA_IN[2:0];
      if (REG_WRITE_IN && REG_ADDR_IN == 8'h14) fmt_r <= REG_WDATA_IN[1:0];
    end
  end
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RESETN_IN);
  property p_latency;
    quiet_r >= 4'hE && div_r == 3'h0 && $changed(OUTPUT_SAMPLE_CLOCK_OUT)
      |-> DATA_OUT == coded($past(SAMPLE_DATA_IN, 12), fmt_r);
  endproperty
  a_latency: assert property (p_latency) else $error("word latency or coding wrong");
  property p_pd;
    wr_pwr && REG_WDATA_IN[1:0] == 2'h1 |=> ##[1:3]
      !(REF_ENABLE_OUT || BIAS_ENABLE_OUT || CORE_CLOCK_ENABLE_OUT || DATA_OE_OUT);
  endproperty
  a_pd: assert property (p_pd) else $error("power-down left a block on");
  property p_standby;
    wr_pwr && REG_WDATA_IN[1:0] == 2'h2 |=> ##[1:3]
      REF_ENABLE_OUT && !CORE_CLOCK_ENABLE_OUT && !DATA_OE_OUT;
  endproperty
  a_standby: assert property (p_standby) else $error("standby state wrong");
  property p_normal;
    wr_pwr && REG_WDATA_IN[1:0] == 2'h0 |=> ##[1:3]
      REF_ENABLE_OUT && BIAS_ENABLE_OUT && CORE_CLOCK_ENABLE_OUT;
  endproperty
  a_normal: assert property (p_normal) else $error("normal mode not active");
  property p_tristate;
    REG_WRITE_IN && REG_ADDR_IN == 8'h14 && REG_WDATA_IN[4] |=> ##[1:3] !DATA_OE_OUT;
  endproperty
  a_tristate: assert property (p_tristate) else $error("outputs still driven");
  property p_mode;
    wr_pwr |=> 2'(POWER_MODE_OUT) == $past(REG_WDATA_IN[1:0]);
  endproperty
  a_mode: assert property (p_mode) else $error("power mode field wrong");
  property p_unmapped;
    REG_READ_IN && !(REG_ADDR_IN inside {8'h08, 8'h09, 8'h0B, 8'h14})
      |=> REG_RDATA_OUT == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_settle;
    $rose(DUTY_CYCLE_RETIMER_ACTIVE_OUT)
      |-> int'(low_r) >= SETTLE_CYC;
  endproperty
  a_settle: assert property (p_settle) else $error("retimer locked too soon");
endmodule
bind acp_top acp_checker #(.W(W), .SETTLE_CYC(SETTLE_CYC)) u_chk (.*);

// [testbench/acp_capture_model.sv]
`timescale 1ns/1ps
module acp_capture_model #(
  parameter int W = 14
) (
  input wire logic         clock_in,
  input wire logic         dco_in,
  input wire logic         dco_oe_in,
  input wire logic [W-1:0] data_in,
  output logic     [W-1:0] word_out,
  output int               count_out
);
  logic dco_q = 1'b0;
  int   n_r   = 0;
  assign count_out = n_r;
  // Each edge of the data clock latches one word into the capture register.
  always @(posedge clock_in) begin
    dco_q <= dco_in;
    if (dco_oe_in === 1'b1 && dco_in !== dco_q) begin
      word_out <= data_in;
      n_r <= n_r + 1;
    end
  end
endmodule

// [testbench/adc_clock_power_output_control_test.sv]
`timescale 1ns/1ps
module adc_clock_power_output_control_test;
  import acp_pkg::*;
  logic          CLOCK_IN = 1'b0, RESETN_IN = 1'b0, REG_WRITE_IN = 1'b0, REG_READ_IN = 1'b0;
  logic          CLOCK_FREQ_CHANGE_IN = 1'b0, CLOCK_RATE_LOW_IN = 1'b0;
  logic [7:0]    REG_ADDR_IN = 8'h00, REG_WDATA_IN = 8'h00, REG_RDATA_OUT;
  logic [13:0]   SAMPLE_DATA_IN = 14'h0000, DATA_OUT, word;
  logic          CONV_CLOCK_OUT, SAMPLE_STROBE_OUT, REF_ENABLE_OUT, BIAS_ENABLE_OUT;
  logic          DUTY_CYCLE_RETIMER_ACTIVE_OUT, DUTY_CYCLE_RETIMER_BYPASS_OUT;
  logic          CORE_CLOCK_ENABLE_OUT, DATA_OE_OUT, REDUCED_SWING_OUT;
  logic          OUTPUT_SAMPLE_CLOCK_OUT, OUTPUT_SAMPLE_CLOCK_OE_OUT;
  acp_pwr_mode_t POWER_MODE_OUT;
  int            err_total = 0, cmp_count = 0, cyc = 0, words, s, c, n0;
  logic [7:0]    d;
  always #50 CLOCK_IN = ~CLOCK_IN;
  acp_top u_dut (.*);
  acp_capture_model u_cap (.clock_in(CLOCK_IN), .dco_in(OUTPUT_SAMPLE_CLOCK_OUT),
    .dco_oe_in(OUTPUT_SAMPLE_CLOCK_OE_OUT), .data_in(DATA_OUT), .word_out(word),
    .count_out(words));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CLOCK_IN);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge CLOCK_IN);
    REG_ADDR_IN <= a;
    REG_WDATA_IN <= v;
    REG_WRITE_IN <= 1'b1;
    @(posedge CLOCK_IN);
    REG_WRITE_IN <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge CLOCK_IN);
    REG_ADDR_IN <= a;
    REG_READ_IN <= 1'b1;
    @(posedge CLOCK_IN);
    REG_READ_IN <= 1'b0;
    #1 d = REG_RDATA_OUT;
  endtask
  task automatic count(input int n);
    s = 0;
    c = 0;
    repeat (n) begin
      @(posedge CLOCK_IN);
      s += int'(SAMPLE_STROBE_OUT === 1'b1);
      c += int'(CONV_CLOCK_OUT === 1'b1);
    end
  endtask
  task automatic code_case(input logic [1:0] f, input logic [13:0] v, input logic [13:0] e);
    wr(8'h14, {6'h00, f});
    SAMPLE_DATA_IN <= v;
    tick(16);
    chk("coded word", {2'h0, e}, {2'h0, word});
  endtask
  task automatic t_regs();
    rd(8'h08);
    chk("power reg", 8'h00, d);
    rd(8'h09);
    chk("retimer reg", 8'h01, d & 8'h7F);
    rd(8'h14);
    chk("output reg", 8'h01, d);
    rd(8'h30);
    chk("unmapped reg", 8'h00, d);
    wr(8'h14, 8'hFF);
    rd(8'h14);
    chk("output reg bits", 8'h53, d);
  endtask
  task automatic t_codes();
    code_case(2'h1, 14'h2000, 14'h0000);
    code_case(2'h1, 14'h0000, 14'h2000);
    code_case(2'h1, 14'h3FFF, 14'h1FFF);
    code_case(2'h0, 14'h0000, 14'h0000);
    code_case(2'h0, 14'h2000, 14'h2000);
    code_case(2'h0, 14'h3FFF, 14'h3FFF);
    code_case(2'h2, 14'h3FFF, 14'h2000);
    code_case(2'h3, 14'h0155, 14'h0155);
  endtask
  task automatic t_stream();
    n0 = words;
    for (int i = 0; i < 30; i++) begin
      @(posedge CLOCK_IN);
      SAMPLE_DATA_IN <= 14'(i * 377);
    end
    #1;
    chk("words per sample", 16'd30, 16'(words - n0));
  endtask
  task automatic t_power();
    wr(8'h08, 8'h01);
    tick(3);
    chk("power-down", 3'h0, {REF_ENABLE_OUT, DATA_OE_OUT, OUTPUT_SAMPLE_CLOCK_OE_OUT});
    chk("power-down bias", 2'h0, {BIAS_ENABLE_OUT, CORE_CLOCK_ENABLE_OUT});
    n0 = words;
    count(20);
    chk("power-down clock", 16'd0, 16'(s + c));
    chk("power-down words", 16'd0, 16'(words - n0));
    wr(8'h08, 8'h02);
    tick(3);
    chk("standby", 2'h2, {REF_ENABLE_OUT, CORE_CLOCK_ENABLE_OUT});
    wr(8'h08, 8'h00);
    tick(3);
    chk("normal", 3'h7, {REF_ENABLE_OUT, BIAS_ENABLE_OUT, DATA_OE_OUT});
    wr(8'h08, 8'h03);
    tick(3);
    chk("mode 11", 3'h7, {REF_ENABLE_OUT, BIAS_ENABLE_OUT, CORE_CLOCK_ENABLE_OUT});
    wr(8'h08, 8'h00);
  endtask
  task automatic t_outputs();
    wr(8'h14, 8'h11);
    tick(3);
    chk("three-state", 2'h0, {DATA_OE_OUT, OUTPUT_SAMPLE_CLOCK_OE_OUT});
    wr(8'h14, 8'h41);
    tick(3);
    chk("reduced swing", 2'h3, {DATA_OE_OUT, REDUCED_SWING_OUT});
  endtask
  task automatic t_divider();
    tick(20);
    for (int r = 1; r <= 8; r++) begin
      wr(8'h0B, 8'(r - 1));
      tick(4);
      chk("locked", 1'b1, DUTY_CYCLE_RETIMER_ACTIVE_OUT);
      count(8 * r);
      chk("strobes", 16'd8, 16'(s));
      chk("locked high time", 16'(8 * ((r + 1) / 2)), 16'(c));
    end
  endtask
  task automatic t_retimer();
    wr(8'h0B, 8'h03);
    CLOCK_RATE_LOW_IN <= 1'b1;
    tick(8);
    chk("low rate", 2'h1, {DUTY_CYCLE_RETIMER_ACTIVE_OUT, DUTY_CYCLE_RETIMER_BYPASS_OUT});
    count(8);
    chk("bypass high time", 16'd2, 16'(c));
    CLOCK_RATE_LOW_IN <= 1'b0;
    tick(30);
    @(posedge CLOCK_IN);
    CLOCK_FREQ_CHANGE_IN <= 1'b1;
    tick(8);
    chk("relock wait", 1'b0, DUTY_CYCLE_RETIMER_ACTIVE_OUT);
    tick(20);
    chk("relocked", 1'b1, DUTY_CYCLE_RETIMER_ACTIVE_OUT);
    @(posedge CLOCK_IN);
    CLOCK_FREQ_CHANGE_IN <= 1'b0;
    wr(8'h09, 8'h00);
    tick(3);
    chk("retimer off", 1'b0, DUTY_CYCLE_RETIMER_ACTIVE_OUT);
  endtask
  task automatic final_report();
    $display("mismatches %0d comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge CLOCK_IN) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      final_report();
    end
  end
  initial begin
    repeat (16) @(posedge CLOCK_IN);
    RESETN_IN <= 1'b1;
    tick(2);
    t_regs();
    t_codes();
    t_stream();
    t_power();
    t_outputs();
    t_divider();
    t_retimer();
    final_report();
  end
endmodule
